// File: design/sar_adc_conversion_sequencer.sv
// successive-approximation converter sequencer with APB register slave
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
module sar_adc_conversion_sequencer
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // power control and analog front end
  input wire logic STANDBY_I,
  input wire logic COMP_I,
  output logic [3:0] CHANNEL_O,
  output logic INPUT_DISABLE_O,
  output logic LADDER_CONNECT_O,
  output logic SAMPLE_O,
  output logic [9:0] DAC_CODE_O,
  // status
  output logic BUSY_O,
  output logic CONV_DONE_IRQ_O
);
  logic [3:0] channel_select;
  logic analog_input_disable;
  logic [1:0] conv_op_mode;
  logic conv_start_bit;
  logic [2:0] time_code;
  logic ladder_connect;
  logic [9:0] result;
  logic conv_done_flag;
  sar_adc_pkg::state_t state;
  sar_adc_pkg::state_t next_state;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic [3:0] bit_idx;
  logic [9:0] trial;
  logic [2:0] comp_sync;
  logic comp_bit;
  logic comp_hold;

  // each code maps to whole conversion length in clock cycles
  function automatic logic [10:0] conv_len(input logic [2:0] code);
    case (code)
      3'b000: conv_len = sar_adc_pkg::CONV_CYC_0;
      3'b010: conv_len = sar_adc_pkg::CONV_CYC_2;
      3'b011: conv_len = sar_adc_pkg::CONV_CYC_3;
      3'b100: conv_len = sar_adc_pkg::CONV_CYC_4;
      3'b101: conv_len = sar_adc_pkg::CONV_CYC_5;
      // reserved codes fall back to the slowest, safest setting
      default: conv_len = sar_adc_pkg::CONV_CYC_6;
    endcase
  endfunction

  // apb decode
  wire setup = PSEL_I & ~PENABLE_I;
  wire access = PSEL_I & PENABLE_I & PREADY_O;
  wire wr = access & PWRITE_I;
  wire rd = access & ~PWRITE_I;
  wire sel_a = PADDR_I == sar_adc_pkg::CTRL_A_OFS;
  wire sel_t = PADDR_I == sar_adc_pkg::TIMING_OFS;
  wire sel_hi = PADDR_I == sar_adc_pkg::RES_HI_OFS;
  wire sel_st = PADDR_I == sar_adc_pkg::RES_ST_OFS;
  wire mapped = sel_a | sel_t | sel_hi | sel_st;
  // registers cannot be written while in standby
  wire wr_a = wr & sel_a & ~STANDBY_I;
  wire wr_t = wr & sel_t & ~STANDBY_I;
  wire [1:0] wr_mode = PWDATA_I[sar_adc_pkg::MODE_LSB +: 2];
  wire rd_hi = rd & sel_hi;

  // read views built from the shared field positions
  logic [7:0] ctrl_a_rd;
  logic [7:0] timing_rd;
  logic [7:0] res_st_rd;
  always_comb
  begin
    ctrl_a_rd = 8'h00;
    ctrl_a_rd[sar_adc_pkg::CH_LSB +: 4] = channel_select;
    ctrl_a_rd[sar_adc_pkg::AIN_DIS_BIT] = analog_input_disable;
    ctrl_a_rd[sar_adc_pkg::MODE_LSB +: 2] = conv_op_mode;
    ctrl_a_rd[sar_adc_pkg::START_BIT] = conv_start_bit;
    // unused timing bits read back as zero
    timing_rd = 8'h00;
    timing_rd[sar_adc_pkg::TIME_LSB +: 3] = time_code;
    timing_rd[sar_adc_pkg::LADDER_BIT] = ladder_connect;
    // low two result bits sit beside the flags
    res_st_rd = 8'h00;
    res_st_rd[sar_adc_pkg::RES_LO_LSB +: 2] = result[1:0];
    res_st_rd[sar_adc_pkg::DONE_BIT] = conv_done_flag;
    res_st_rd[sar_adc_pkg::BUSY_BIT] = BUSY_O;
  end
  wire [7:0] rd_mux = sel_a ? ctrl_a_rd :
                      sel_t ? timing_rd :
                      sel_hi ? result[9:2] :
                      sel_st ? res_st_rd : 8'h00;

  // sequencing
  wire [10:0] len = conv_len(time_code);
  wire [10:0] slot = 11'(len / 11'(sar_adc_pkg::SLOT_DIV));
  wire [10:0] sample_len = 11'(len - 11'(sar_adc_pkg::SAR_BITS) * slot);
  wire mode_ok = conv_op_mode == sar_adc_pkg::MODE_SW || conv_op_mode == sar_adc_pkg::MODE_REPEAT;
  wire launch = conv_start_bit & mode_ok & (state == sar_adc_pkg::ST_IDLE);
  wire abort = STANDBY_I | (wr_a & wr_mode == sar_adc_pkg::MODE_OFF);
  wire slot_end = cnt == 11'h000;
  wire finish = (state == sar_adc_pkg::ST_CONVERT) & slot_end & (bit_idx == 4'h0) & ~abort;
  wire repeat_on = conv_op_mode == sar_adc_pkg::MODE_REPEAT;

  // a comparator change counts only once second and third stages agree
  assign comp_bit = (comp_sync[2] == comp_sync[1]) ? comp_sync[2] : comp_hold;
  wire [9:0] bit_mask = 10'h001 << bit_idx;
  wire [9:0] decided = comp_bit ? trial : (trial & ~bit_mask);
  wire [9:0] next_trial = decided | (bit_mask >> 1);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    if (abort)
    begin
      next_state = sar_adc_pkg::ST_IDLE;
      next_cnt = 11'h000;
    end
    else
    begin
      case (state)
        sar_adc_pkg::ST_IDLE:
        begin
          if (launch)
          begin
            next_state = sar_adc_pkg::ST_SAMPLE;
            next_cnt = 11'(sample_len - 11'h001);
          end
        end
        sar_adc_pkg::ST_SAMPLE:
        begin
          next_cnt = 11'(cnt - 11'h001);
          if (slot_end)
          begin
            next_state = sar_adc_pkg::ST_CONVERT;
            next_cnt = 11'(slot - 11'h001);
          end
        end
        sar_adc_pkg::ST_CONVERT:
        begin
          next_cnt = 11'(cnt - 11'h001);
          if (finish)
          begin
            // back-to-back conversions in repeat mode
            next_state = repeat_on ? sar_adc_pkg::ST_SAMPLE : sar_adc_pkg::ST_IDLE;
            next_cnt = 11'(sample_len - 11'h001);
          end
          else if (slot_end)
            next_cnt = 11'(slot - 11'h001);
        end
        default:
        begin
          next_state = sar_adc_pkg::ST_IDLE;
          next_cnt = 11'h000;
        end
      endcase
    end
  end

  // comparator crosses in from the analog side
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      comp_sync <= 3'h0;
      comp_hold <= 1'b0;
    end
    else
    begin
      comp_sync <= {comp_sync[1:0], COMP_I};
      comp_hold <= comp_bit;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      state <= sar_adc_pkg::ST_IDLE;
      cnt <= 11'h000;
      BUSY_O <= 1'b0;
      SAMPLE_O <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      BUSY_O <= next_state != sar_adc_pkg::ST_IDLE;
      SAMPLE_O <= next_state == sar_adc_pkg::ST_SAMPLE;
    end
  end

  // binary search, msb first
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      bit_idx <= 4'h0;
      DAC_CODE_O <= 10'h000;
      trial <= 10'h000;
    end
    else if (next_state == sar_adc_pkg::ST_SAMPLE || abort)
    begin
      bit_idx <= 4'(sar_adc_pkg::SAR_BITS - 1);
      trial <= 10'h200;
      DAC_CODE_O <= 10'h200;
    end
    else if (state == sar_adc_pkg::ST_CONVERT && slot_end)
    begin
      bit_idx <= 4'(bit_idx - 4'h1);
      trial <= next_trial;
      DAC_CODE_O <= next_trial;
    end
  end

  // control registers; standby forces them back to reset values
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I || STANDBY_I)
    begin
      {conv_start_bit, conv_op_mode, analog_input_disable, channel_select} <= sar_adc_pkg::CTRL_A_RST;
      {ladder_connect, time_code} <= {sar_adc_pkg::TIMING_RST[sar_adc_pkg::LADDER_BIT],
                                      sar_adc_pkg::TIMING_RST[sar_adc_pkg::TIME_LSB +: 3]};
    end
    else
    begin
      if (wr_a)
      begin
        channel_select <= PWDATA_I[sar_adc_pkg::CH_LSB +: 4];
        analog_input_disable <= PWDATA_I[sar_adc_pkg::AIN_DIS_BIT];
        conv_op_mode <= wr_mode;
      end
      // start bit lives one cycle only, whether or not it launched
      conv_start_bit <= wr_a & PWDATA_I[sar_adc_pkg::START_BIT];
      if (wr_t)
      begin
        time_code <= PWDATA_I[sar_adc_pkg::TIME_LSB +: 3];
        ladder_connect <= PWDATA_I[sar_adc_pkg::LADDER_BIT];
      end
    end
  end

  // result and completion flag
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I || STANDBY_I)
    begin
      result <= 10'h000;
      conv_done_flag <= 1'b0;
      CONV_DONE_IRQ_O <= 1'b0;
    end
    else
    begin
      if (finish)
        result <= decided;
      // completion wins over a clear in the same cycle
      conv_done_flag <= finish | (conv_done_flag & ~(rd_hi | launch));
      CONV_DONE_IRQ_O <= finish;
    end
  end

  // analog-facing outputs
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      CHANNEL_O <= 4'h0;
      INPUT_DISABLE_O <= 1'b0;
      LADDER_CONNECT_O <= 1'b0;
    end
    else
    begin
      CHANNEL_O <= channel_select;
      INPUT_DISABLE_O <= analog_input_disable;
      LADDER_CONNECT_O <= ladder_connect & ~STANDBY_I;
    end
  end

  // apb answer: read data captured in setup, ready in the access cycle
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & ~mapped;
      if (setup)
        PRDATA_O <= {24'h000000, rd_mux};
    end
  end
endmodule

// File: design/sar_adc_pkg.sv
// constants and types shared by the converter sequencer
package sar_adc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_A_OFS = 12'h000;
  localparam logic [11:0] TIMING_OFS = 12'h004;
  localparam logic [11:0] RES_HI_OFS = 12'h008;
  localparam logic [11:0] RES_ST_OFS = 12'h00C;
  localparam int CH_LSB = 0;
  localparam int AIN_DIS_BIT = 4;
  localparam int MODE_LSB = 5;
  localparam int START_BIT = 7;
  localparam int TIME_LSB = 1;
  localparam int LADDER_BIT = 5;
  localparam int RES_LO_LSB = 6;
  localparam int DONE_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam int SAR_BITS = 10;
  localparam int SLOT_DIV = 13;
  localparam logic [10:0] CONV_CYC_0 = 11'd39;
  localparam logic [10:0] CONV_CYC_2 = 11'd78;
  localparam logic [10:0] CONV_CYC_3 = 11'd156;
  localparam logic [10:0] CONV_CYC_4 = 11'd312;
  localparam logic [10:0] CONV_CYC_5 = 11'd624;
  localparam logic [10:0] CONV_CYC_6 = 11'd1248;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SW = 2'b01,
    MODE_RSV = 2'b10,
    MODE_REPEAT = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } state_t;
endpackage

// File: testbench/sar_adc_conversion_sequencer_tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_conversion_sequencer_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic stby = 1'h0;
  logic comp = 1'h0;
  logic [9:0] ain = 10'h000;
  logic [31:0] prd, r;
  logic prdy, perr, pe, ladder, busy, irq, ind, smp;
  logic [3:0] ch;
  logic [9:0] dac;
  int miscompares = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  // ideal comparator, one flop late like a real sampled pin
  always @(posedge clk) comp <= ain >= dac;
  sar_adc_conversion_sequencer dut_u
  (
    .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .STANDBY_I(stby), .COMP_I(comp), .CHANNEL_O(ch), .INPUT_DISABLE_O(ind),
    .LADDER_CONNECT_O(ladder), .SAMPLE_O(smp), .DAC_CODE_O(dac), .BUSY_O(busy),
    .CONV_DONE_IRQ_O(irq)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'h1;
    // ready is judged mid-cycle, where it has settled
    @(negedge clk);
    while (prdy !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      miscompares++;
      $display("[ERR] pready expected 1 seen %b", prdy);
    end
    r = prd;
    pe = perr;
    @(posedge clk);
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'h0, a, 8'h00);
    chk(nm, {24'h0, e}, r);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    @(negedge clk);
    while (irq !== 1'h1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      miscompares++;
      $display("[ERR] irq expected 1 seen %b", irq);
    end
    @(posedge clk);
  endtask
  task automatic t_reset();
    rd(12'h000, 8'h00, "ctrl_rst");
    rd(12'h00C, 8'h00, "status_rst");
    rd(12'h010, 8'h00, "unmapped");
    chk("slverr", 32'h1, {31'h0, pe});
    apb(1'h1, 12'h000, 8'hC0);
    repeat (3) @(posedge clk);
    chk("rsv_mode", 32'h0, {31'h0, busy});
    rd(12'h000, 8'h40, "rsv_ctrl");
  endtask
  task automatic t_single();
    int n;
    ain = 10'h2B7;
    apb(1'h1, 12'h000, 8'h23);
    apb(1'h1, 12'h004, 8'h24);
    apb(1'h1, 12'h000, 8'hA3);
    rd(12'h000, 8'h23, "start_clear");
    wait_irq(n);
    chk("channel", 32'h3, {28'h0, ch});
    rd(12'h00C, 8'hE0, "status");
    rd(12'h008, 8'hAD, "result_hi");
    rd(12'h00C, 8'hC0, "done_clear");
    ain = 10'h001;
    apb(1'h1, 12'h000, 8'hA3);
    wait_irq(n);
    ain = 10'h2B7;
    apb(1'h1, 12'h000, 8'hA3);
    rd(12'h00C, 8'h50, "restart");
    wait_irq(n);
    rd(12'h00C, 8'hE0, "overwrite");
  endtask
  task automatic t_repeat();
    int n;
    ain = 10'h155;
    apb(1'h1, 12'h000, 8'hE3);
    wait_irq(n);
    @(posedge clk);
    chk("rerun", 32'h1, {31'h0, busy});
    wait_irq(n);
    chk("second", 32'h1, {31'h0, n < 100});
    rd(12'h008, 8'h55, "repeat_hi");
    ain = 10'h3FF;
    repeat (20) @(posedge clk);
    apb(1'h1, 12'h000, 8'h13);
    rd(12'h008, 8'h55, "abort_keep");
    chk("abort_busy", 32'h0, {31'h0, busy});
    chk("in_dis", 32'h1, {31'h0, ind});
  endtask
  task automatic t_times();
    int lim[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};
    int n;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'h1, 12'h004, 8'h20 | 8'(i * 2));
      rd(12'h004, 8'h20 | 8'(i * 2), "timing");
      apb(1'h1, 12'h000, 8'hA0);
      wait_irq(n);
      chk("conv_time", 32'h1, {31'h0, n >= lim[i] - 4 && n <= lim[i] + 4});
    end
  endtask
  task automatic t_standby();
    apb(1'h1, 12'h004, 8'h24);
    apb(1'h1, 12'h000, 8'hA3);
    repeat (10) @(posedge clk);
    chk("ladder_on", 32'h1, {31'h0, ladder});
    chk("sampling", 32'h1, {31'h0, smp});
    stby <= 1'h1;
    repeat (2) @(posedge clk);
    chk("ladder_off", 32'h0, {31'h0, ladder});
    chk("halt", 32'h0, {31'h0, busy});
    apb(1'h1, 12'h000, 8'hA3);
    stby <= 1'h0;
    rd(12'h000, 8'h00, "ctrl_clr");
    rd(12'h004, 8'h00, "timing_clr");
    rd(12'h008, 8'h00, "result_lost");
    repeat (50) @(posedge clk);
    chk("no_resume", 32'h0, {31'h0, busy});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_single();
    t_repeat();
    t_times();
    t_standby();
    complete_run();
  end
  // about four times the expected run
  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
bind sar_adc_conversion_sequencer sar_adc_props chk_u
(
  .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .STANDBY_I(STANDBY_I), .CHANNEL_O(CHANNEL_O), .LADDER_CONNECT_O(LADDER_CONNECT_O),
  .BUSY_O(BUSY_O), .CONV_DONE_IRQ_O(CONV_DONE_IRQ_O)
);

// File: testbench/sar_adc_props.sv
// port assertions for the converter sequencer
`timescale 1ns/100ps
module sar_adc_props
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // watched ports
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic STANDBY_I,
  input wire logic [3:0] CHANNEL_O,
  input wire logic LADDER_CONNECT_O,
  input wire logic BUSY_O,
  input wire logic CONV_DONE_IRQ_O
);
  wire logic wr_ctl;
  wire logic go;
  assign wr_ctl = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == 12'h000;
  // bit five set covers both launching modes
  assign go = wr_ctl && PWDATA_I[7] && PWDATA_I[5] && !BUSY_O && !STANDBY_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_irq_pulse: assert property (CONV_DONE_IRQ_O |=> !CONV_DONE_IRQ_O)
    else $error("irq longer than one cycle");
  a_start_launch: assert property (go |-> ##[1:3] BUSY_O)
    else $error("start did not launch");
  a_min_time: assert property ($rose(BUSY_O) |-> !CONV_DONE_IRQ_O [*8])
    else $error("done too early");
  a_abort_now: assert property (wr_ctl && PWDATA_I[6:5] == 2'h0 |-> ##[1:2] !BUSY_O)
    else $error("disable did not halt");
  a_ladder_off: assert property (STANDBY_I |=> !LADDER_CONNECT_O)
    else $error("ladder on in standby");
  a_standby_halt: assert property (STANDBY_I |=> !BUSY_O)
    else $error("busy in standby");
  a_no_resume: assert property ($fell(STANDBY_I) |-> !BUSY_O [*3])
    else $error("resumed after standby");
  a_chan_copy: assert property (wr_ctl && !STANDBY_I |=> ##1
    CHANNEL_O == $past(PWDATA_I[3:0], 2))
    else $error("channel not applied");
endmodule
